// *** shared/sloac_pkg.sv ***
// package: constants, states and carriers for the serial link oob / activity controller
package sloac_pkg;

   // clock and oob timing
   localparam int CLK_PERIOD_PS = 100000;
   localparam int OOB_T1_PS     = 106700;
   localparam int OOB_T2_PS     = 320000;
   // least times round up to whole cycles, never below one
   localparam int OOB_T1_CYC    = ((OOB_T1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                                  ((OOB_T1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int OOB_T2_CYC    = ((OOB_T2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
                                  ((OOB_T2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int OOB_GAP_MAX   = 2 * OOB_T2_CYC;
   localparam int OOB_BURSTS    = 6;
   localparam int TX_BURST_CYC  = 2;
   localparam logic [3:0] T1_CYC_W  = 4'(OOB_T1_CYC);
   localparam logic [3:0] T2_CYC_W  = 4'(OOB_T2_CYC);
   localparam logic [3:0] GAP_MAX_W = 4'(OOB_GAP_MAX);
   localparam logic [3:0] BURST_W   = 4'(TX_BURST_CYC);
   localparam logic [2:0] BURSTS_W  = 3'(OOB_BURSTS);

   // activity indicator timing
   localparam int MS_PS               = 1000000000;
   localparam int MS_CYC              = MS_PS / CLK_PERIOD_PS;
   localparam int ACT_LONG_PERIOD_MS  = 200;
   localparam int ACT_SHORT_PERIOD_MS = 100;
   localparam int ACT_LONG_HALF_MS    = ACT_LONG_PERIOD_MS / 2;
   localparam int ACT_SHORT_HALF_MS   = ACT_SHORT_PERIOD_MS / 2;

   // link states, one-hot
   typedef enum logic [7:0] {
      ST_NOCOMM    = 8'h01,
      ST_INIT_TX   = 8'h02,
      ST_WAIT_WAKE = 8'h04,
      ST_WAKE_TX   = 8'h08,
      ST_ALIGN     = 8'h10,
      ST_READY     = 8'h20,
      ST_PARTIAL   = 8'h40,
      ST_SLUMBER   = 8'h80
   } sloac_state_e;

   // oob burst kinds sent by this end, one-hot
   typedef enum logic [1:0] {
      TX_INIT = 2'h1,
      TX_WAKE = 2'h2
   } sloac_txk_e;

   typedef struct packed {
      logic active;    // a command is executing
      logic fmt_ws;    // it is a format or write-same command
   } sloac_cmd_s;

   typedef struct packed {
      logic burst;     // burst on the line, low means common-mode idle
      logic cominit;   // a cominit sequence is being sent
      logic comwake;   // a comwake sequence is being sent
   } sloac_tx_s;

   typedef struct packed {
      logic comreset;  // comreset sequence recognised
      logic comwake;   // comwake sequence recognised
      logic loss;      // loss of signal seen
      logic recovered; // link left the no-communication state after a loss
      logic sig_req;   // send the signature now
   } sloac_ev_s;

endpackage : sloac_pkg

// *** rtl/sloac_blink.sv ***
// activity indicator toggle timer
`timescale 1ns/100ps
`default_nettype none
module sloac_blink #(
   parameter int MS_CYC  = sloac_pkg::MS_CYC,
   parameter int LONG_MS = sloac_pkg::ACT_LONG_HALF_MS,
   parameter int SHRT_MS = sloac_pkg::ACT_SHORT_HALF_MS
) (
   input  wire logic              ref_clk_i,
   input  wire logic              nrst_i,
   input  wire sloac_pkg::sloac_cmd_s cmd_i,
   output logic                   act_o
);
   import sloac_pkg::*;

   localparam int DW = $clog2(MS_CYC + 1);
   localparam int MW = $clog2(LONG_MS + SHRT_MS + 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(MS_CYC - 1);
   localparam logic [MW-1:0] LONG_LAST = MW'(LONG_MS - 1);
   localparam logic [MW-1:0] SHRT_LAST = MW'(SHRT_MS - 1);

   logic [DW-1:0] div_r, div_nxt;
   logic [MW-1:0] ms_r, ms_nxt;
   logic          act_r, act_nxt;
   logic          run_r, run_nxt;
   logic          tick;

   // millisecond enable pulse from the divider
   assign tick = (div_r == DIV_LAST);

   // next values: restart on a new command, toggle at each half period
   always_comb
   begin
      div_nxt = (div_r == DIV_LAST) ? '0 : div_r + DW'(1);
      ms_nxt  = ms_r;
      act_nxt = act_r;
      run_nxt = cmd_i.active;
      if (cmd_i.active && !run_r)
      begin
         div_nxt = '0;                                      // R14
         ms_nxt  = '0;
         act_nxt = 1'b1;
      end
      else if (cmd_i.active)
      begin
         if (tick)
         begin
            if (ms_r == (cmd_i.fmt_ws ? LONG_LAST : SHRT_LAST)) // R12 R13
            begin
               ms_nxt  = '0;
               act_nxt = !act_r;
            end
            else
            begin
               ms_nxt = ms_r + MW'(1);
            end
         end
      end
      else
      begin
         act_nxt = 1'b0;                                    // R14
         ms_nxt  = '0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         div_r <= '0;
         ms_r  <= '0;
         act_r <= 1'b0;
         run_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         ms_r  <= ms_nxt;
         act_r <= act_nxt;
         run_r <= run_nxt;
      end
   end

   assign act_o = act_r;

   chk_idle_stays_low: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R14
      !cmd_i.active |=> !act_o)
      else $error("activity indicator not low while idle");

   chk_half_toggle: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R12
      (cmd_i.active && run_r && tick && ms_r == (cmd_i.fmt_ws ? LONG_LAST : SHRT_LAST))
      |=> (act_o != $past(act_o)))
      else $error("activity indicator missed its half-period toggle");

   chk_no_early_flip: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R13
      (cmd_i.active && run_r && !tick) |=> (act_o == $past(act_o)))
      else $error("activity indicator flipped between ms ticks");

endmodule : sloac_blink
`default_nettype wire

// *** rtl/sloac_top.sv ***
// serial link oob sequencing, signal-loss recovery and power-segment pin control
// Summary of operation
// R1 - generate and detect comreset, cominit and comwake out-of-band sequences; the code sends cominit and comwake, detects comreset and comwake
// R2 - each burst is followed by common-mode idle of 106.7 ns or 320 ns; the code idles 2 or 4 cycles, 200 ns or 400 ns
// R3 - a received comwake brings partial or slumber back to active
// R4 - leaving link ready for not ready counts as loss of signal
// R5 - recovery is leaving no-communication; power-down drop of ready is no loss
// R6 - after a device-started cominit sequence completes, return the signature
// R7 - host answers an unsolicited cominit with comreset
// R8 - host then loads shadow status 7Fh and other shadow registers FFh
// R9 - host shows attached device with shadow status FFh or 80h
// R10 - power-segment pin is spin-up input before ready, activity output after
// R11 - host uses the power-segment pin for one function only
// R12 - format and write-same: 100 ms high then 100 ms low
// R13 - other commands: activity indicator toggles on a 100 ms period
// R14 - indicator low when idle; timer restarts at each new command
`timescale 1ns/100ps
`default_nettype none
module sloac_top #(
   parameter int MS_CYC = sloac_pkg::MS_CYC
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  nrst_i,
   input  wire logic                  rx_burst_i,
   input  wire logic                  phy_lock_i,
   input  wire logic                  phy_lost_i,
   input  wire logic                  pm_partial_i,
   input  wire logic                  pm_slumber_i,
   input  wire logic                  recover_en_i,
   input  wire sloac_pkg::sloac_cmd_s cmd_i,
   input  wire logic                  p11_i,
   output sloac_pkg::sloac_tx_s       tx_o,
   output sloac_pkg::sloac_ev_s       ev_o,
   output logic                       phyrdy_o,
   output logic                       spinup_dis_o,
   output logic                       p11_o,
   output logic                       p11_oe_o
);
   import sloac_pkg::*;

   // receive classifier state
   logic       rx_prev_r, rx_prev_nxt;
   logic       rx_seen_r, rx_seen_nxt;
   logic       rx_cls_r,  rx_cls_nxt;   // 1: 320 ns spacing, 0: 106.7 ns spacing
   logic [3:0] rx_gap_r,  rx_gap_nxt;
   logic [2:0] rx_cnt_r,  rx_cnt_nxt;
   logic       det_rst_r, det_rst_nxt;
   logic       det_wak_r, det_wak_nxt;
   logic       cls;

   // spacing between received bursts picks the sequence; a burst train
   // with mixed spacing restarts the count instead of being guessed at
   always_comb
   begin
      rx_prev_nxt = rx_burst_i;
      rx_seen_nxt = rx_seen_r;
      rx_cls_nxt  = rx_cls_r;
      rx_gap_nxt  = rx_gap_r;
      rx_cnt_nxt  = rx_cnt_r;
      det_rst_nxt = 1'b0;
      det_wak_nxt = 1'b0;
      cls         = (rx_gap_r > T1_CYC_W);
      if (rx_burst_i && !rx_prev_r)
      begin
         rx_gap_nxt  = '0;
         rx_seen_nxt = 1'b1;
         if (rx_seen_r)
         begin
            rx_cls_nxt = cls;
            rx_cnt_nxt = (rx_cnt_r != '0 && cls != rx_cls_r) ? 3'h1 : rx_cnt_r + 3'h1;
            if (rx_cnt_nxt == BURSTS_W - 3'h1)
            begin
               det_rst_nxt = cls;                           // R1
               det_wak_nxt = !cls;                          // R1
               rx_cnt_nxt  = '0;
               rx_seen_nxt = 1'b0;
            end
         end
      end
      else if (rx_burst_i)
      begin
         rx_gap_nxt = '0;
      end
      else if (rx_gap_r > GAP_MAX_W)
      begin
         rx_seen_nxt = 1'b0;                                // idle too long, drop train
         rx_cnt_nxt  = '0;
      end
      else
      begin
         rx_gap_nxt = rx_gap_r + 4'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rx_prev_r <= 1'b0;
         rx_seen_r <= 1'b0;
         rx_cls_r  <= 1'b0;
         rx_gap_r  <= '0;
         rx_cnt_r  <= '0;
         det_rst_r <= 1'b0;
         det_wak_r <= 1'b0;
      end
      else
      begin
         rx_prev_r <= rx_prev_nxt;
         rx_seen_r <= rx_seen_nxt;
         rx_cls_r  <= rx_cls_nxt;
         rx_gap_r  <= rx_gap_nxt;
         rx_cnt_r  <= rx_cnt_nxt;
         det_rst_r <= det_rst_nxt;
         det_wak_r <= det_wak_nxt;
      end
   end

   // link state machine
   sloac_state_e state_r, state_nxt;
   logic         lost_r,  lost_nxt;
   logic         unsol_r, unsol_nxt;
   sloac_ev_s    ev_r,    ev_nxt;
   logic         tx_go;
   logic         tx_done_r;

   always_comb
   begin
      state_nxt = state_r;
      lost_nxt  = lost_r;
      unsol_nxt = unsol_r;
      ev_nxt    = '0;
      ev_nxt.comreset = det_rst_r;
      ev_nxt.comwake  = det_wak_r;
      unique case (state_r)
         ST_NOCOMM:
            if (det_rst_r)
            begin
               state_nxt = ST_INIT_TX;
               unsol_nxt = 1'b0;
            end
            else if (lost_r && recover_en_i)
            begin
               state_nxt = ST_INIT_TX;                      // R6
               unsol_nxt = 1'b1;
            end
         ST_INIT_TX:
            if (tx_done_r)
               state_nxt = ST_WAIT_WAKE;
         ST_WAIT_WAKE:
            if (det_rst_r)
            begin
               state_nxt = ST_INIT_TX;                      // R7
               unsol_nxt = 1'b0;
            end
            else if (det_wak_r)
               state_nxt = ST_WAKE_TX;
         ST_WAKE_TX:
            if (tx_done_r)
               state_nxt = ST_ALIGN;
         ST_ALIGN:
            if (phy_lock_i)
            begin
               state_nxt      = ST_READY;
               ev_nxt.sig_req = 1'b1;                       // R6
               unsol_nxt      = 1'b0;
            end
         ST_READY:
            if (det_rst_r)
               state_nxt = ST_INIT_TX;
            else if (phy_lost_i)
            begin
               state_nxt   = ST_NOCOMM;                     // R4
               ev_nxt.loss = 1'b1;
               lost_nxt    = 1'b1;
            end
            else if (pm_partial_i)
               state_nxt = ST_PARTIAL;                      // R5
            else if (pm_slumber_i)
               state_nxt = ST_SLUMBER;                      // R5
         ST_PARTIAL, ST_SLUMBER:
            if (det_rst_r)
               state_nxt = ST_INIT_TX;
            else if (det_wak_r)
               state_nxt = ST_WAKE_TX;                      // R3
         default:
            state_nxt = ST_NOCOMM;
      endcase
      // leaving no-communication after a loss is the recovery point
      if (state_r == ST_NOCOMM && state_nxt != ST_NOCOMM && lost_r)
      begin
         ev_nxt.recovered = 1'b1;                           // R5
         lost_nxt         = 1'b0;
      end
   end

   assign tx_go = (state_nxt != state_r) &&
                  (state_nxt == ST_INIT_TX || state_nxt == ST_WAKE_TX);

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r <= ST_NOCOMM;
         lost_r  <= 1'b0;
         unsol_r <= 1'b0;
         ev_r    <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         lost_r  <= lost_nxt;
         unsol_r <= unsol_nxt;
         ev_r    <= ev_nxt;
      end
   end

   // transmit burst sequencer
   sloac_tx_s  tx_r, tx_nxt;
   logic       tx_busy_r, tx_busy_nxt;
   logic [3:0] tx_cnt_r,  tx_cnt_nxt;
   logic [2:0] tx_num_r,  tx_num_nxt;
   logic       tx_done_nxt;

   always_comb
   begin
      tx_nxt      = tx_r;
      tx_busy_nxt = tx_busy_r;
      tx_cnt_nxt  = tx_cnt_r;
      tx_num_nxt  = tx_num_r;
      tx_done_nxt = 1'b0;
      if (tx_go)
      begin
         tx_busy_nxt    = 1'b1;
         tx_nxt.burst   = 1'b1;                             // R1
         tx_nxt.cominit = (state_nxt == ST_INIT_TX);
         tx_nxt.comwake = (state_nxt == ST_WAKE_TX);
         tx_cnt_nxt     = BURST_W - 4'h1;
         tx_num_nxt     = BURSTS_W - 3'h1;
      end
      else if (tx_busy_r)
      begin
         if (tx_cnt_r != '0)
            tx_cnt_nxt = tx_cnt_r - 4'h1;
         else if (tx_r.burst)
         begin
            tx_nxt.burst = 1'b0;                            // R2
            tx_cnt_nxt   = (tx_r.comwake ? T1_CYC_W : T2_CYC_W) - 4'h1;
         end
         else if (tx_num_r != '0)
         begin
            tx_nxt.burst = 1'b1;
            tx_num_nxt   = tx_num_r - 3'h1;
            tx_cnt_nxt   = BURST_W - 4'h1;
         end
         else
         begin
            tx_busy_nxt = 1'b0;
            tx_nxt      = '0;
            tx_done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tx_r      <= '0;
         tx_busy_r <= 1'b0;
         tx_cnt_r  <= '0;
         tx_num_r  <= '0;
         tx_done_r <= 1'b0;
      end
      else
      begin
         tx_r      <= tx_nxt;
         tx_busy_r <= tx_busy_nxt;
         tx_cnt_r  <= tx_cnt_nxt;
         tx_num_r  <= tx_num_nxt;
         tx_done_r <= tx_done_nxt;
      end
   end

   // power-segment pin: direction follows link ready so the pin never
   // drives while the host may still be driving spin-up control
   logic act;
   logic rdy_r, rdy_nxt;
   logic pin_o_r, pin_o_nxt;
   logic spin_r, spin_nxt;

   sloac_blink #(
      .MS_CYC  (MS_CYC),
      .LONG_MS (ACT_LONG_HALF_MS),
      .SHRT_MS (ACT_SHORT_HALF_MS)
   ) u_blink (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .cmd_i     (cmd_i),
      .act_o     (act)
   );

   always_comb
   begin
      rdy_nxt   = (state_nxt == ST_READY);
      pin_o_nxt = rdy_nxt && act;                           // R10
      spin_nxt  = rdy_r ? spin_r : p11_i;                   // R10
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rdy_r   <= 1'b0;
         pin_o_r <= 1'b0;
         spin_r  <= 1'b0;
      end
      else
      begin
         rdy_r   <= rdy_nxt;
         pin_o_r <= pin_o_nxt;
         spin_r  <= spin_nxt;
      end
   end

   assign tx_o         = tx_r;
   assign ev_o         = ev_r;
   assign phyrdy_o     = rdy_r;
   assign p11_oe_o     = rdy_r;
   assign p11_o        = pin_o_r;
   assign spinup_dis_o = spin_r;

   sequence seq_wake_gap;
      !tx_o.burst [*2];
   endsequence
   sequence seq_init_gap;
      !tx_o.burst [*4];
   endsequence

   chk_wake_spacing: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R2
      ($fell(tx_o.burst) && tx_o.comwake) |-> seq_wake_gap)
      else $error("comwake idle shorter than spacing");

   chk_init_spacing: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R2
      ($fell(tx_o.burst) && tx_o.cominit) |-> seq_init_gap)
      else $error("cominit idle shorter than spacing");

   chk_wake_exits_pm: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R3
      ((state_r == ST_PARTIAL || state_r == ST_SLUMBER) && det_wak_r && !det_rst_r)
      |=> ##1 tx_o.comwake)
      else $error("comwake did not leave power-down");

   chk_loss_on_drop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R4
      ev_o.loss |-> (!phyrdy_o && $past(phyrdy_o)))
      else $error("loss flagged without ready dropping");

   chk_pm_not_loss: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R5
      ($fell(phyrdy_o) && (state_r == ST_PARTIAL || state_r == ST_SLUMBER)) |-> !ev_o.loss)
      else $error("power-down taken as loss of signal");

   chk_sig_after_oob: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R6
      ev_o.sig_req |-> (phyrdy_o && $past(state_r == ST_ALIGN)))
      else $error("signature not tied to completed oob sequence");

   chk_pin_dir: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R10
      !phyrdy_o |-> (!p11_oe_o && !p11_o))
      else $error("power-segment pin driven before ready");

   chk_spin_sample: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R10
      !phyrdy_o |=> (spinup_dis_o == $past(p11_i)))
      else $error("spin-up control not sampled before ready");

endmodule : sloac_top
`default_nettype wire

// *** dv/sloac_host_model.sv ***
// host-side partner: oob sequences, shadow status and spin-up drive
`timescale 1ns/100ps
`default_nettype none
module sloac_host_model (
   input  wire logic                  ref_clk_i,
   input  wire logic                  nrst_i,
   input  wire sloac_pkg::sloac_tx_s  dev_tx_i,
   input  wire logic                  phyrdy_i,
   input  wire logic                  wake_req_i,
   input  wire logic                  spin_dis_i,
   output logic                       rx_burst_o,
   output logic                       phy_lock_o,
   output logic                       p11_en_o,
   output logic                       p11_val_o
);
   import sloac_pkg::*;

   logic [7:0] shadow_status_r;
   logic [7:0] shadow_other_r;
   logic       awaiting_r;
   logic       wake_l;

   // spin-up control only before the link is ready, pin released afterwards
   assign p11_en_o  = !phyrdy_i;
   assign p11_val_o = spin_dis_i;

   // six bursts, each followed by common-mode idle of the given length
   task automatic send_seq(input int gap);
      phy_lock_o = 1'b0;
      for (int b = 0; b < OOB_BURSTS; b++)
      begin
         rx_burst_o = 1'b1;
         repeat (TX_BURST_CYC) @(posedge ref_clk_i);
         #5 rx_burst_o = 1'b0;
         repeat (gap) @(posedge ref_clk_i);
         #5;
      end
   endtask : send_seq

   // lock only after the device's own comwake, as a real phy would align then
   task automatic wake_and_lock;
      send_seq(OOB_T1_CYC);
      @(negedge dev_tx_i.comwake);
      @(posedge ref_clk_i);
      #5 phy_lock_o = 1'b1;
   endtask : wake_and_lock

   // host sequencing: power-on comreset, then answer every cominit
   initial
   begin
      rx_burst_o      = 1'b0;
      phy_lock_o      = 1'b0;
      shadow_status_r = 8'hFF;
      shadow_other_r  = 8'hFF;
      awaiting_r      = 1'b0;
      wake_l          = 1'b0;
      @(posedge nrst_i);
      repeat (3) @(posedge ref_clk_i);
      #5 awaiting_r = 1'b1;
      send_seq(OOB_T2_CYC);
      forever
      begin
         @(negedge dev_tx_i.cominit or posedge wake_req_i);
         wake_l = wake_req_i;
         @(posedge ref_clk_i);
         #5;
         if (wake_l)
            wake_and_lock();
         else if (awaiting_r)
         begin
            shadow_status_r = 8'h80;
            awaiting_r      = 1'b0;
            wake_and_lock();
         end
         else
         begin
            shadow_status_r = 8'h7F;
            shadow_other_r  = 8'hFF;
            awaiting_r      = 1'b1;
            send_seq(OOB_T2_CYC);
         end
      end
   end
endmodule : sloac_host_model
`default_nettype wire

// *** dv/sloac_top_tb.sv ***
// self-checking bench for the oob, recovery and power-segment pin block
`timescale 1ns/100ps
`default_nettype none
`define CHECK_EQ(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAIT_FOR(c, n) for (int k = 0; k < (n) && !(c); k++) step(1);
module sloac_top_tb;
   import sloac_pkg::*;

   localparam int SIM_MS     = 4;
   localparam int SHORT_HALF = ACT_SHORT_HALF_MS * SIM_MS;
   localparam int LONG_HALF  = ACT_LONG_HALF_MS * SIM_MS;

   logic       ref_clk, nrst, phy_lost, pm_partial, pm_slumber, recover_en;
   logic       wake_req, spin_dis, rx_burst, phy_lock, host_en, host_val, p11_pin;
   logic       phyrdy, spinup_dis, p11, p11_oe, seq_p;
   sloac_cmd_s cmd;
   sloac_tx_s  tx;
   sloac_ev_s  ev;
   int         mismatches, total_checks, n_comreset, n_comwake, n_loss, n_rec, n_sig;
   int         gap, bursts;

   // pin level: device, else host, else the pull-up
   assign p11_pin = p11_oe ? p11 : (host_en ? host_val : 1'b1);

   sloac_top #(.MS_CYC(SIM_MS)) dut_u (
      .ref_clk_i(ref_clk), .nrst_i(nrst), .rx_burst_i(rx_burst), .phy_lock_i(phy_lock),
      .phy_lost_i(phy_lost), .pm_partial_i(pm_partial), .pm_slumber_i(pm_slumber),
      .recover_en_i(recover_en), .cmd_i(cmd), .p11_i(p11_pin), .tx_o(tx), .ev_o(ev),
      .phyrdy_o(phyrdy), .spinup_dis_o(spinup_dis), .p11_o(p11), .p11_oe_o(p11_oe)
   );

   sloac_host_model host_u (
      .ref_clk_i(ref_clk), .nrst_i(nrst), .dev_tx_i(tx), .phyrdy_i(phyrdy),
      .wake_req_i(wake_req), .spin_dis_i(spin_dis), .rx_burst_o(rx_burst),
      .phy_lock_o(phy_lock), .p11_en_o(host_en), .p11_val_o(host_val)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask : step

   // event pulses are tallied here so tasks can judge them at leisure
   always @(posedge ref_clk)
   begin
      if (nrst)
      begin
         n_comreset += ev.comreset;
         n_comwake  += ev.comwake;
         n_loss     += ev.loss;
         n_rec      += ev.recovered;
         n_sig      += ev.sig_req;
         if (ev.sig_req) `CHECK_EQ(phyrdy, 1'b1)
         if (tx.burst && bursts > 0 && gap > 0)
            `CHECK_EQ(gap, tx.cominit ? OOB_T2_CYC : OOB_T1_CYC)
         if (tx.burst && gap > 0 || tx.burst && bursts == 0) bursts++;
         gap = (tx.burst || bursts == 0) ? 0 : gap + 1;
         if (seq_p && !(tx.cominit || tx.comwake))
         begin
            `CHECK_EQ(bursts, OOB_BURSTS)
            bursts = 0;
            gap    = 0;
         end
         seq_p = tx.cominit || tx.comwake;
      end
   end

   task automatic t_bringup;
      `CHECK_EQ(spinup_dis, 1'b1)
      `CHECK_EQ(p11_oe, 1'b0)
      `WAIT_FOR(phyrdy === 1'b1, 400)
      step(2);
      `CHECK_EQ(phyrdy, 1'b1)
      `CHECK_EQ(n_comreset, 1)
      `CHECK_EQ(n_sig, 1)
      `CHECK_EQ(host_u.shadow_status_r, 8'h80)
      `CHECK_EQ(p11_oe, 1'b1)
      `CHECK_EQ(spinup_dis, 1'b1)
      `CHECK_EQ(p11_pin, 1'b0)
   endtask : t_bringup

   // an aborted command first, so the full phase proves the timer restarted
   task automatic t_act(input logic fmt, input int half);
      int n;
      cmd = '{active: 1'b1, fmt_ws: fmt};
      step(50);
      `CHECK_EQ(p11_pin, 1'b1)
      cmd.active = 1'b0;
      step(3);
      `CHECK_EQ(p11, 1'b0)
      cmd.active = 1'b1;
      step(2);
      for (n = 0; p11 === 1'b1 && n < 1000; n++) step(1);
      `CHECK_EQ(n, half)
      for (n = 0; p11 === 1'b0 && n < 1000; n++) step(1);
      `CHECK_EQ(n, half)
      cmd.active = 1'b0;
      step(half + 3);
      `CHECK_EQ(p11, 1'b0)
   endtask : t_act

   task automatic t_power(input logic slumber);
      int l0;
      int w0;
      l0         = n_loss;
      w0         = n_comwake;
      spin_dis   = slumber;
      pm_slumber = slumber;
      pm_partial = !slumber;
      `WAIT_FOR(phyrdy === 1'b0, 5)
      pm_slumber = 1'b0;
      pm_partial = 1'b0;
      step(20);
      `CHECK_EQ(n_loss, l0)
      `CHECK_EQ(p11_oe, 1'b0)
      `CHECK_EQ(spinup_dis, slumber)
      wake_req = 1'b1;
      step(1);
      wake_req = 1'b0;
      `WAIT_FOR(phyrdy === 1'b1, 200)
      step(2);
      `CHECK_EQ(phyrdy, 1'b1)
      `CHECK_EQ(n_comwake, w0 + 1)
      `CHECK_EQ(spinup_dis, slumber)
   endtask : t_power

   task automatic t_loss;
      int l0;
      int r0;
      int s0;
      int c0;
      l0         = n_loss;
      r0         = n_rec;
      s0         = n_sig;
      c0         = n_comreset;
      recover_en = 1'b1;
      phy_lost   = 1'b1;
      `WAIT_FOR(phyrdy === 1'b0, 5)
      phy_lost = 1'b0;
      step(2);
      `CHECK_EQ(n_loss, l0 + 1)
      `CHECK_EQ(n_rec, r0 + 1)
      `WAIT_FOR(host_u.shadow_status_r === 8'h7F, 200)
      `CHECK_EQ(host_u.shadow_status_r, 8'h7F)
      `CHECK_EQ(host_u.shadow_other_r, 8'hFF)
      `WAIT_FOR(phyrdy === 1'b1, 400)
      step(2);
      `CHECK_EQ(host_u.shadow_status_r, 8'h80)
      `CHECK_EQ(n_sig, s0 + 1)
      `CHECK_EQ(n_comreset, c0 + 1)
      recover_en = 1'b0;
   endtask : t_loss

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   // main sequence
   initial
   begin
      {nrst, phy_lost, pm_partial, pm_slumber, recover_en, wake_req, seq_p} = '0;
      {mismatches, total_checks, n_comreset, n_comwake, n_loss, n_rec, n_sig} = '0;
      {gap, bursts} = '0;
      spin_dis      = 1'b1;
      cmd           = '0;
      step(10);
      nrst = 1'b1;
      step(5);
      t_bringup();
      t_act(1'b0, SHORT_HALF);
      t_act(1'b1, LONG_HALF);
      t_power(1'b1);
      t_power(1'b0);
      t_loss();
      end_sim();
   end

   // hang guard, well beyond the few thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      end_sim();
   end
endmodule : sloac_top_tb
`default_nettype wire
